// File: sensor_bank_consts.vh
`ifndef SENSOR_BANK_CONSTS_VH
`define SENSOR_BANK_CONSTS_VH
// command bytes: region[7:5], address[4:1], read flag[0]
`define CMD_REGION_HI      7
`define CMD_REGION_LO      5
`define CMD_ADDR_HI        4
`define CMD_ADDR_LO        1
`define CMD_READ_BIT       0
`define REGION_NVM         3'h0
`define REGION_REG         3'h4
`define CMD_STATUS_WR      8'h82
`define CMD_STATUS_RD      8'h83
`define CMD_KEY_WR         8'h94
`define CMD_PROG_WR        8'h96
`define CMD_PROG_RD        8'h97
`define UNLOCK_KEY         16'h16F4
// control_status fields
`define ST_DIAG            15
`define ST_OVERRIDE        14
`define ST_UNDERVOLT       12
`define ST_PUMP            11
`define ST_SINGLE_ERR      8
`define ST_DOUBLE_ERR      7
`define ST_FIELD_LOST      6
`define ST_CRC_BAD         4
// programming_control field
`define PC_WRITE_EN        11
// customer writable nvm word range
`define NVM_CUST_FIRST     4'h8
`define NVM_CUST_LAST      4'hF
// entry window: 125 MHz clock, window in microseconds
// kept short so a test run can watch the window close
`define CLOCK_MHZ          125
`define ENTRY_WINDOW_US    20
// last counted cycle: 20 us at 125 MHz, less one
`define ENTRY_WINDOW_LAST  20'h009C3
`define WIN_CNT_W          20
`endif

// File: status_capture.v
`include "sensor_bank_consts.vh"
// sticky diagnostic flag: set by event, held until por even after condition gone
module status_capture (
	input  wire clock,
	input  wire rstn,
	input  wire sample,
	input  wire cond,
	output reg  flag_r
);
	wire flag_nxt;
	assign flag_nxt = sample ? (flag_r | cond) : flag_r;
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			flag_r <= 1'b0;
		else
			flag_r <= flag_nxt;
	end
endmodule

// File: sensor_command_register_bank.v
// Summary of operation
// - key 16F4h at 94h within window unlocks
// - bit 15 shows true diagnostic condition
// - bit 14 write-only diagnostic override, reset zero
// - bit 12 read-only undervoltage flag
// - bit 11 pump clock enable, read/write
// - bit 8 sticky corrected single-bit error
// - bit 7 sticky uncorrectable double-bit error
// - bit 6 sticky field loss, gated diagnostics
// - bit 4 checksum mismatch, sampled at start-up
// - programming_control bit 11 write enable
// - unlocked: read status and nvm, others read zero; write customer only
// - command byte region, address, read flag
// - write is command plus two data bytes
// - command mode disables analog output
`include "sensor_bank_consts.vh"
module sensor_command_register_bank (
	input  wire        clock,
	input  wire        rstn,
	input  wire        cmd_valid,
	input  wire [7:0]  cmd_byte,
	input  wire [15:0] cmd_wdata,
	input  wire        undervoltage_in,
	input  wire        field_lost_in,
	input  wire        field_loss_enable,
	input  wire        single_err_in,
	input  wire        double_err_in,
	input  wire        nvm_readout,
	input  wire        crc_mismatch_in,
	input  wire        startup_check,
	input  wire [15:0] nvm_rdata,
	output reg  [15:0] rdata_r,
	output reg         rvalid_r,
	output reg         command_mode_r,
	output reg         analog_enable_r,
	output reg         diagnostic_active_r,
	output reg         diag_output_r,
	output reg         pump_clock_enable_r,
	output reg         write_enable_r,
	output reg         nvm_write_r,
	output reg         nvm_read_r,
	output reg  [3:0]  nvm_addr_r,
	output reg  [15:0] nvm_wdata_r
);
	// pins from the analog side pass two flops
	reg  [5:0] sync1_r;
	reg  [5:0] sync2_r;
	wire [5:0] pins_in;
	assign pins_in = {crc_mismatch_in, double_err_in, single_err_in,
		field_loss_enable, field_lost_in, undervoltage_in};
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
		end else begin
			sync1_r <= pins_in;
			sync2_r <= sync1_r;
		end
	end
	// synced levels lag the pins by two cycles
	wire uv_s      = sync2_r[0];
	wire lost_s    = sync2_r[1];
	wire loss_en_s = sync2_r[2];
	wire serr_s    = sync2_r[3];
	wire derr_s    = sync2_r[4];
	wire crc_s     = sync2_r[5];

	reg  [`WIN_CNT_W-1:0] win_cnt_r;
	reg                   window_open_r;
	reg                   diagnostic_override_r;
	wire                  single_flag;
	wire                  double_flag;
	wire                  lost_flag;
	reg                   crc_bad_r;

	wire [2:0] region = cmd_byte[`CMD_REGION_HI:`CMD_REGION_LO];
	wire [3:0] addr   = cmd_byte[`CMD_ADDR_HI:`CMD_ADDR_LO];
	wire       is_rd  = cmd_byte[`CMD_READ_BIT];
	wire       wr     = cmd_valid & ~is_rd;
	wire       rd     = cmd_valid & is_rd;

	status_capture u_single (
		.clock  (clock),
		.rstn   (rstn),
		.sample (nvm_readout),
		.cond   (serr_s),
		.flag_r (single_flag)
	);
	status_capture u_double (
		.clock  (clock),
		.rstn   (rstn),
		.sample (nvm_readout),
		.cond   (derr_s),
		.flag_r (double_flag)
	);
	status_capture u_lost (
		.clock  (clock),
		.rstn   (rstn),
		.sample (1'b1),
		.cond   (lost_s),
		.flag_r (lost_flag)
	);

	// field loss counts only when enabled
	wire lost_diag = lost_flag & loss_en_s;
	wire diag_now  = double_flag | crc_bad_r | uv_s | lost_diag;

	wire [15:0] status_word;
	assign status_word = ({15'h0000, diagnostic_active_r} << `ST_DIAG)
		| ({15'h0000, uv_s} << `ST_UNDERVOLT)
		| ({15'h0000, pump_clock_enable_r} << `ST_PUMP)
		| ({15'h0000, single_flag} << `ST_SINGLE_ERR)
		| ({15'h0000, double_flag} << `ST_DOUBLE_ERR)
		| ({15'h0000, lost_flag} << `ST_FIELD_LOST)
		| ({15'h0000, crc_bad_r} << `ST_CRC_BAD);

	// customer words sit in the top half
	wire cust_addr = (addr >= `NVM_CUST_FIRST);

	// key inside window or while diagnostic
	wire key_ok    = wr && (cmd_byte == `CMD_KEY_WR)
		&& (cmd_wdata == `UNLOCK_KEY)
		&& (window_open_r || diagnostic_active_r);
	wire status_wr = command_mode_r && wr
		&& (cmd_byte == `CMD_STATUS_WR);
	wire prog_wr   = command_mode_r && wr
		&& (cmd_byte == `CMD_PROG_WR);
	wire reg_rd    = command_mode_r && rd;
	wire nvm_wr_ok = command_mode_r && wr && (region == `REGION_NVM)
		&& cust_addr && write_enable_r && pump_clock_enable_r;

	// entry window counts from power-on
	// counter parks once shut, so the window never reopens
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			win_cnt_r     <= {`WIN_CNT_W{1'b0}};
			window_open_r <= 1'b1;
		end else if (window_open_r) begin
			if (win_cnt_r == `ENTRY_WINDOW_LAST)
				window_open_r <= 1'b0;
			else
				win_cnt_r <= win_cnt_r + 1'b1;
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			command_mode_r        <= 1'b0;
			analog_enable_r       <= 1'b1;
			diagnostic_override_r <= 1'b0;
			pump_clock_enable_r   <= 1'b0;
			write_enable_r        <= 1'b0;
			crc_bad_r             <= 1'b0;
			diagnostic_active_r   <= 1'b0;
			diag_output_r         <= 1'b0;
			rdata_r               <= 16'h0000;
			rvalid_r              <= 1'b0;
			nvm_write_r           <= 1'b0;
			nvm_read_r            <= 1'b0;
			nvm_addr_r            <= 4'h0;
			nvm_wdata_r           <= 16'h0000;
		end else begin
			rvalid_r    <= 1'b0;
			nvm_write_r <= 1'b0;
			nvm_read_r  <= 1'b0;
			if (startup_check)
				crc_bad_r <= crc_s;
			diagnostic_active_r <= diag_now;
			// override masks the diagnostic output
			// it hides the pin level only; bit 15 stays true
			diag_output_r <= diag_now & ~diagnostic_override_r;
			if (key_ok) begin
				command_mode_r <= 1'b1;
				// analog output off in command mode
				analog_enable_r <= 1'b0;
			end
			// write carries command and 16 data bits
			if (status_wr) begin
				diagnostic_override_r <= cmd_wdata[`ST_OVERRIDE];
				pump_clock_enable_r <= cmd_wdata[`ST_PUMP];
			end
			if (prog_wr)
				write_enable_r <= cmd_wdata[`PC_WRITE_EN];
			// region decode for reads
			// reserved regions still answer, with zero
			if (reg_rd) begin
				rvalid_r <= 1'b1;
				if (cmd_byte == `CMD_STATUS_RD)
					rdata_r <= status_word;
				else
					rdata_r <= 16'h0000;
				if (region == `REGION_NVM) begin
					nvm_read_r <= 1'b1;
					nvm_addr_r <= addr;
					rdata_r    <= nvm_rdata;
				end
			end
			if (nvm_wr_ok) begin
				nvm_write_r <= 1'b1;
				nvm_addr_r  <= addr;
				nvm_wdata_r <= cmd_wdata;
			end
		end
	end
endmodule

// File: sensor_bank_sva.sv
module sensor_bank_sva (
	input logic        clock,
	input logic        rstn,
	input logic        cmd_valid,
	input logic [7:0]  cmd_byte,
	input logic [15:0] cmd_wdata,
	input logic        rvalid_r,
	input logic        command_mode_r,
	input logic        analog_enable_r,
	input logic        diagnostic_active_r,
	input logic        diag_output_r,
	input logic        pump_clock_enable_r,
	input logic        write_enable_r,
	input logic        nvm_write_r,
	input logic [3:0]  nvm_addr_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] age_r;
	wire        rd_reg = cmd_byte[7:5] == 3'h4 && cmd_byte[0];
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// age only matters well inside the entry window
	always_ff @(posedge clock or negedge rstn)
		if (!rstn)
			age_r <= 10'h0;
		else if (!age_r[9])
			age_r <= age_r + 10'h1;
	AST_KEY:
	assert property (cmd_valid && cmd_byte == 8'h94 && cmd_wdata == 16'h16F4
		&& !age_r[9] |=> command_mode_r) else $error("key refused");
	AST_LOCK:
	assert property (cmd_valid && !command_mode_r |=> !rvalid_r && !nvm_write_r)
		else $error("locked access answered");
	AST_ANALOG:
	assert property (command_mode_r |-> !analog_enable_r) else $error("analog on");
	AST_OVR:
	assert property (cmd_valid && command_mode_r && cmd_byte == 8'h82
		&& cmd_wdata[14] |=> ##1 !diag_output_r) else $error("override");
	AST_WE:
	assert property (nvm_write_r |-> write_enable_r && pump_clock_enable_r)
		else $error("nvm write not enabled");
	AST_CUST:
	assert property (nvm_write_r |-> nvm_addr_r[3]) else $error("reserved write");
	AST_RD:
	assert property (cmd_valid && command_mode_r && rd_reg |=> rvalid_r)
		else $error("no read answer");
	AST_PUMP:
	assert property (cmd_valid && command_mode_r && cmd_byte == 8'h82
		|=> pump_clock_enable_r == $past(cmd_wdata[11])) else $error("pump");
	cover property ($rose(command_mode_r));
	cover property (nvm_write_r);
	cover property (rvalid_r && diagnostic_active_r);
endmodule
bind sensor_command_register_bank sensor_bank_sva u_chk (
	.clock               (clock),
	.rstn                (rstn),
	.cmd_valid           (cmd_valid),
	.cmd_byte            (cmd_byte),
	.cmd_wdata           (cmd_wdata),
	.rvalid_r            (rvalid_r),
	.command_mode_r      (command_mode_r),
	.analog_enable_r     (analog_enable_r),
	.diagnostic_active_r (diagnostic_active_r),
	.diag_output_r       (diag_output_r),
	.pump_clock_enable_r (pump_clock_enable_r),
	.write_enable_r      (write_enable_r),
	.nvm_write_r         (nvm_write_r),
	.nvm_addr_r          (nvm_addr_r)
);

// File: prog_master.sv
module prog_master #(parameter int TPROG = 8) (
	input  logic        clock,
	output logic        cmd_valid,
	output logic [7:0]  cmd_byte,
	output logic [15:0] cmd_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
		cmd_wdata = 16'h0000;
	end
	task automatic xfer(input logic [7:0] c, input logic [15:0] d);
		@(negedge clock);
		cmd_valid <= 1'b1;
		cmd_byte <= c;
		cmd_wdata <= d;
		@(negedge clock);
		cmd_valid <= 1'b0;
		// released lines must not look like the last word
		cmd_byte <= ~c;
		cmd_wdata <= ~d;
		if (c[7:5] == 3'h0 && !c[0])
			repeat (TPROG) @(negedge clock);
	endtask
endmodule

// File: sensor_command_register_bank_bench.sv
module sensor_command_register_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rstn, cmd_valid, undervoltage_in, field_lost_in;
	logic        field_loss_enable, single_err_in, double_err_in, nvm_readout;
	logic        crc_mismatch_in, startup_check, rvalid_r, command_mode_r;
	logic        analog_enable_r, diagnostic_active_r, diag_output_r;
	logic        pump_clock_enable_r, write_enable_r, nvm_write_r, nvm_read_r;
	logic [3:0]  nvm_addr_r;
	logic [7:0]  cmd_byte;
	logic [15:0] cmd_wdata, nvm_rdata, rdata_r, nvm_wdata_r, d;
	logic [19:0] q[$];
	int          num_errors, cmp_count;
	integer      seed;
	sensor_command_register_bank u_dut (.*);
	prog_master u_master (.*);
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic chk(input logic [19:0] s, input logic [19:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		q.push_back({4'h0, e});
		if (c[7:5] == 3'h0)
			q.push_back({c[4:1], 16'h0000});
		u_master.xfer(c, 16'h0000);
	endtask
	function automatic logic [19:0] nxt();
		return q.size() ? q.pop_front() : 20'hFFFFF;
	endfunction
	// unexpected answers meet an impossible note
	always @(negedge clock) begin
		if (rvalid_r)
			chk({4'h0, rdata_r}, nxt());
		if (nvm_read_r)
			chk({nvm_addr_r, 16'h0000}, nxt());
		if (nvm_write_r)
			chk({nvm_addr_r, nvm_wdata_r}, nxt());
	end
	initial begin
		seed = 32'h54CEF6F8;
		{rstn, undervoltage_in, field_lost_in, field_loss_enable} = 4'h0;
		{single_err_in, double_err_in, nvm_readout, crc_mismatch_in} = 4'h0;
		startup_check = 1'b0;
		nvm_rdata = 16'h0000;
		repeat (16) @(negedge clock);
		rstn = 1'b1;
		u_master.xfer(8'h83, 16'h0000);
		u_master.xfer(8'h94, 16'h16F5);
		chk(command_mode_r, 1'b0);
		u_master.xfer(8'h94, 16'h16F4);
		chk({command_mode_r, analog_enable_r}, 2'h2);
		repeat (4) begin
			d = $random(seed) & 16'hF7FF;
			u_master.xfer(8'h82, d);
			rd(8'h83, 16'h0000);
		end
		rd(8'h97, 16'h0000);
		u_master.xfer(8'h96, 16'h0800);
		chk(write_enable_r, 1'b1);
		u_master.xfer(8'h82, 16'h0800);
		rd(8'h83, 16'h0800);
		d = $random(seed);
		q.push_back({4'h8, d});
		u_master.xfer(8'h10, d);
		u_master.xfer(8'h0E, d);
		for (int i = 8; i < 16; i++) begin
			nvm_rdata = $random(seed);
			rd({3'h0, 4'(i), 1'b1}, nvm_rdata);
		end
		{undervoltage_in, single_err_in, double_err_in, crc_mismatch_in} = 4'hF;
		repeat (4) @(negedge clock);
		{nvm_readout, startup_check} = 2'h3;
		@(negedge clock);
		{nvm_readout, startup_check, single_err_in, double_err_in} = 4'h0;
		repeat (4) @(negedge clock);
		rd(8'h83, 16'h9990);
		chk({diagnostic_active_r, diag_output_r}, 2'h3);
		u_master.xfer(8'h82, 16'h4800);
		@(negedge clock);
		chk({diagnostic_active_r, diag_output_r}, 2'h2);
		{undervoltage_in, crc_mismatch_in} = 2'h0;
		rstn = 1'b0;
		repeat (4) @(negedge clock);
		rstn = 1'b1;
		@(negedge clock);
		chk({command_mode_r, analog_enable_r, diagnostic_active_r}, 3'h2);
		repeat (2600) @(negedge clock);
		u_master.xfer(8'h94, 16'h16F4);
		chk(command_mode_r, 1'b0);
		field_lost_in = 1'b1;
		repeat (4) @(negedge clock);
		u_master.xfer(8'h94, 16'h16F4);
		chk({command_mode_r, diagnostic_active_r}, 2'h0);
		field_loss_enable = 1'b1;
		repeat (4) @(negedge clock);
		u_master.xfer(8'h94, 16'h16F4);
		chk({command_mode_r, diagnostic_active_r}, 2'h3);
		field_lost_in = 1'b0;
		d = $random(seed);
		u_master.xfer(8'h10, d);
		rd(8'h83, 16'h8040);
		field_loss_enable = 1'b0;
		repeat (4) @(negedge clock);
		rd(8'h83, 16'h0040);
		repeat (4) @(negedge clock);
		chk(20'(q.size()), 20'h0);
		wrap_up();
	end
	initial begin
		repeat (6000) @(posedge clock);
		num_errors++;
		wrap_up();
	end
endmodule
